// ---- src/fcpo_pkg.sv ----
package fcpo_pkg;

  // ------------------------------------------------------------------
  // Widths and field layout
  // ------------------------------------------------------------------
  localparam int LEN_W = 16;              // frame length in bytes
  localparam int OFS_W = 8;               // signed offset byte
  localparam int TOK_W = 26;              // signed token count
  localparam int RATE_W = 16;             // tokens per refill tick
  localparam int DIV_W = 16;              // refill tick divider
  localparam int BKT_W = 24;              // burst size field

  typedef logic signed [TOK_W-1:0] fcpo_tok_t;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OFS    = 8'h04;
  localparam logic [7:0] ADDR_CRATE  = 8'h08;
  localparam logic [7:0] ADDR_CCAP   = 8'h0C;
  localparam logic [7:0] ADDR_CBURST = 8'h10;
  localparam logic [7:0] ADDR_ERATE  = 8'h14;
  localparam logic [7:0] ADDR_ECAP   = 8'h18;
  localparam logic [7:0] ADDR_EBURST = 8'h1C;
  localparam logic [7:0] ADDR_DIV    = 8'h20;
  localparam logic [7:0] ADDR_CTOK   = 8'h24;
  localparam logic [7:0] ADDR_ETOK   = 8'h28;
  localparam logic [7:0] ADDR_GCNT   = 8'h2C;
  localparam logic [7:0] ADDR_RCNT   = 8'h30;

  // Control bits
  localparam int CTRL_LI  = 0;            // length-independent mode
  localparam int CTRL_EN  = 1;            // bucket refill enable

  // Reset values and AXI response codes
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0013;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // Color codes
  typedef enum logic [1:0] {
    FCPO_GREEN  = 2'b00,
    FCPO_YELLOW = 2'b01,
    FCPO_RED    = 2'b11
  } fcpo_color_e;

endpackage

// ---- src/fcpo_policer.sv ----
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
module fcpo_policer
  import fcpo_pkg::*;
(
  input  wire logic             i_clk,        // 20 MHz clock
  input  wire logic             i_arst_n,     // Async reset, low
  input  wire logic             i_frm_valid,  // Frame length offered
  input  wire logic [LEN_W-1:0] i_frm_len,    // Frame length, bytes
  input  wire logic             i_frm_prof,   // Frame has a profile
  output logic                  o_col_valid,  // Color result pulse
  output logic [1:0]            o_col,        // Declared color
  input  wire logic [7:0]       i_awaddr,     // AXI write address
  input  wire logic             i_awvalid,    // AXI
  output logic                  o_awready,    // AXI
  input  wire logic [31:0]      i_wdata,      // AXI write data
  input  wire logic [3:0]       i_wstrb,      // AXI byte strobes
  input  wire logic             i_wvalid,     // AXI
  output logic                  o_wready,     // AXI
  output logic [1:0]            o_bresp,      // AXI
  output logic                  o_bvalid,     // AXI
  input  wire logic             i_bready,     // AXI
  input  wire logic [7:0]       i_araddr,     // AXI read address
  input  wire logic             i_arvalid,    // AXI
  output logic                  o_arready,    // AXI
  output logic [31:0]           o_rdata,      // AXI read data
  output logic [1:0]            o_rresp,      // AXI
  output logic                  o_rvalid,     // AXI
  input  wire logic             i_rready      // AXI
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Byte-strobe merge of a write word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Refill a bucket by min(rate, cap), saturate at burst
  function automatic fcpo_tok_t refill(input fcpo_tok_t t, input logic [RATE_W-1:0] rate,
                                       input logic [RATE_W-1:0] cap,
                                       input logic [BKT_W-1:0] bs);
    fcpo_tok_t add;
    fcpo_tok_t sum;
    fcpo_tok_t lim;
    add = (rate < cap) ? fcpo_tok_t'(rate) : fcpo_tok_t'(cap);
    lim = fcpo_tok_t'(bs);
    sum = t + add;
    return (sum > lim) ? lim : sum;
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0]        ctrl_r, ctrl_nxt;
  logic [OFS_W-1:0]   ofs_r, ofs_nxt;
  logic [RATE_W-1:0]  crate_r, crate_nxt, ccap_r, ccap_nxt;
  logic [RATE_W-1:0]  erate_r, erate_nxt, ecap_r, ecap_nxt;
  logic [BKT_W-1:0]   cburst_r, cburst_nxt, eburst_r, eburst_nxt;
  logic [DIV_W-1:0]   div_r, div_nxt;
  logic               bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]         bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic               wr_go, rd_go;
  logic [31:0]        gcnt_r, gcnt_nxt, rcnt_r, rcnt_nxt;

  assign o_awready = i_awvalid && i_wvalid && !bvalid_r;
  assign o_wready  = o_awready;
  assign o_arready = !rvalid_r;
  assign wr_go     = o_awready;
  assign rd_go     = i_arvalid && o_arready;

  // ------------------------------------------------------------------
  // Policer datapath
  // ------------------------------------------------------------------
  fcpo_tok_t        ctok_r, ctok_nxt, etok_r, etok_nxt;
  fcpo_tok_t        req, ctok_ref, etok_ref;
  logic [DIV_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic             tick;
  logic             col_valid_r, col_valid_nxt;
  logic [1:0]       col_r, col_nxt;
  logic             c_ok, e_ok, li_mode;

  assign li_mode = ctrl_r[CTRL_LI];
  // Charge = length minus signed offset
  assign req = fcpo_tok_t'(i_frm_len) - fcpo_tok_t'($signed(ofs_r));
  assign tick = ctrl_r[CTRL_EN] && (tick_cnt_r == '0);

  // Tick divider, refill, and color decision
  always_comb begin
    tick_cnt_nxt  = tick_cnt_r;
    ctok_nxt      = ctok_r;
    etok_nxt      = etok_r;
    col_valid_nxt = 1'b0;
    col_nxt       = col_r;
    gcnt_nxt      = gcnt_r;
    rcnt_nxt      = rcnt_r;
    if (ctrl_r[CTRL_EN]) begin
      tick_cnt_nxt = (tick_cnt_r == '0) ? div_r : tick_cnt_r - 1'b1;
    end
    ctok_ref = tick ? refill(ctok_r, crate_r, ccap_r, cburst_r) : ctok_r;
    etok_ref = tick ? refill(etok_r, erate_r, ecap_r, eburst_r) : etok_r;
    ctok_nxt = ctok_ref;
    etok_nxt = etok_ref;
    c_ok = li_mode ? (ctok_ref > 0) : (ctok_ref >= req);
    e_ok = li_mode ? (etok_ref > 0) : (etok_ref >= req);
    if (i_frm_valid) begin
      col_valid_nxt = 1'b1;
      if (!i_frm_prof) begin
        col_nxt  = FCPO_GREEN;
        gcnt_nxt = gcnt_r + 1'b1;
      end else if (c_ok) begin
        col_nxt  = FCPO_GREEN;
        ctok_nxt = ctok_ref - req;
        gcnt_nxt = gcnt_r + 1'b1;
      end else if (e_ok) begin
        col_nxt  = FCPO_YELLOW;
        etok_nxt = etok_ref - req;
      end else begin
        col_nxt  = FCPO_RED;
        rcnt_nxt = rcnt_r + 1'b1;
      end
    end
  end

  // Policer state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_r  <= '0;
      ctok_r      <= '0;
      etok_r      <= '0;
      col_valid_r <= 1'b0;
      col_r       <= FCPO_GREEN;
      gcnt_r      <= '0;
      rcnt_r      <= '0;
    end else begin
      tick_cnt_r  <= tick_cnt_nxt;
      ctok_r      <= ctok_nxt;
      etok_r      <= etok_nxt;
      col_valid_r <= col_valid_nxt;
      col_r       <= col_nxt;
      gcnt_r      <= gcnt_nxt;
      rcnt_r      <= rcnt_nxt;
    end
  end

  assign o_col_valid = col_valid_r;
  assign o_col       = col_r;

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  // Register writes and read mux
  always_comb begin
    ctrl_nxt   = ctrl_r;
    ofs_nxt    = ofs_r;
    crate_nxt  = crate_r;
    ccap_nxt   = ccap_r;
    cburst_nxt = cburst_r;
    erate_nxt  = erate_r;
    ecap_nxt   = ecap_r;
    eburst_nxt = eburst_r;
    div_nxt    = div_r;
    bvalid_nxt = bvalid_r && !i_bready;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r && !i_rready;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OK;
      case (i_awaddr)
        ADDR_CTRL:  ctrl_nxt  = merge(ctrl_r, i_wdata, i_wstrb) & 32'h0000_0003;
        ADDR_OFS:   ofs_nxt   = i_wstrb[0] ? i_wdata[OFS_W-1:0] : ofs_r;
        ADDR_CRATE: crate_nxt = RATE_W'(merge({16'h0000, crate_r}, i_wdata, i_wstrb));
        ADDR_CCAP:  ccap_nxt  = RATE_W'(merge({16'h0000, ccap_r}, i_wdata, i_wstrb));
        ADDR_CBURST: cburst_nxt = BKT_W'(merge({8'h00, cburst_r}, i_wdata, i_wstrb));
        ADDR_ERATE: erate_nxt = RATE_W'(merge({16'h0000, erate_r}, i_wdata, i_wstrb));
        ADDR_ECAP:  ecap_nxt  = RATE_W'(merge({16'h0000, ecap_r}, i_wdata, i_wstrb));
        ADDR_EBURST: eburst_nxt = BKT_W'(merge({8'h00, eburst_r}, i_wdata, i_wstrb));
        ADDR_DIV:   div_nxt   = DIV_W'(merge({16'h0000, div_r}, i_wdata, i_wstrb));
        ADDR_CTOK, ADDR_ETOK, ADDR_GCNT, ADDR_RCNT: bresp_nxt = RESP_OK;
        default:    bresp_nxt = RESP_ERR;
      endcase
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OK;
      case (i_araddr)
        ADDR_CTRL:  rdata_nxt = ctrl_r;
        ADDR_OFS:   rdata_nxt = {24'h00_0000, ofs_r};
        ADDR_CRATE: rdata_nxt = {16'h0000, crate_r};
        ADDR_CCAP:  rdata_nxt = {16'h0000, ccap_r};
        ADDR_CBURST: rdata_nxt = {8'h00, cburst_r};
        ADDR_ERATE: rdata_nxt = {16'h0000, erate_r};
        ADDR_ECAP:  rdata_nxt = {16'h0000, ecap_r};
        ADDR_EBURST: rdata_nxt = {8'h00, eburst_r};
        ADDR_DIV:   rdata_nxt = {16'h0000, div_r};
        ADDR_CTOK:  rdata_nxt = 32'(ctok_r);
        ADDR_ETOK:  rdata_nxt = 32'(etok_r);
        ADDR_GCNT:  rdata_nxt = gcnt_r;
        ADDR_RCNT:  rdata_nxt = rcnt_r;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_ERR;
        end
      endcase
    end
  end

  // Register state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r   <= CTRL_RST;
      ofs_r    <= '0;
      crate_r  <= '0;
      ccap_r   <= '0;
      cburst_r <= '0;
      erate_r  <= '0;
      ecap_r   <= '0;
      eburst_r <= '0;
      div_r    <= DIV_RST;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OK;
      rdata_r  <= '0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      ofs_r    <= ofs_nxt;
      crate_r  <= crate_nxt;
      ccap_r   <= ccap_nxt;
      cburst_r <= cburst_nxt;
      erate_r  <= erate_nxt;
      ecap_r   <= ecap_nxt;
      eburst_r <= eburst_nxt;
      div_r    <= div_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp  = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rresp  = rresp_r;
  assign o_rdata  = rdata_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_unprof_green: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && !i_frm_prof |=> o_col_valid && o_col == FCPO_GREEN)
    else $error("unprofiled frame not green");
  a_std_green_fits: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && !li_mode && ctok_ref >= req |=> o_col == FCPO_GREEN)
    else $error("fitting frame not green");
  a_std_red: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && !li_mode && ctok_ref < req && etok_ref < req
    |=> o_col == FCPO_RED)
    else $error("frame not red");
  a_li_green: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && li_mode && ctok_ref > 0 |=> o_col == FCPO_GREEN)
    else $error("li mode frame not green");
  a_li_deduct: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && c_ok |=> ctok_r == $past(ctok_ref) - $past(req))
    else $error("green charge wrong");
  a_req_offset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    req == fcpo_tok_t'(i_frm_len) - fcpo_tok_t'($signed(ofs_r)))
    else $error("request offset wrong");
  a_burst_cap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tick && !i_frm_valid |=> ctok_r <= fcpo_tok_t'($past(cburst_r)) || ctok_r == $past(ctok_r))
    else $error("burst cap exceeded");
  a_rate_cap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_frm_valid && ctok_r >= 0 |=> ctok_r - $past(ctok_r) <= fcpo_tok_t'($past(ccap_r)))
    else $error("refill above cap");

  // Colour choice, negative excursion and pulse timing
  a_std_yellow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && !li_mode && ctok_ref < req && etok_ref >= req
    |=> o_col == FCPO_YELLOW)
    else $error("excess frame not yellow");
  a_li_red: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && li_mode && ctok_ref <= 0 && etok_ref <= 0
    |=> o_col == FCPO_RED)
    else $error("li mode frame not red");
  a_li_neg_bound: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && i_frm_prof && li_mode && ctok_ref > 0 |=> ctok_r + $past(req) > 0)
    else $error("negative excursion too deep");
  a_unprof_keep: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_frm_valid && !i_frm_prof && !tick
    |=> ctok_r == $past(ctok_r) && etok_r == $past(etok_r))
    else $error("unprofiled frame touched a bucket");
  a_col_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    1'b1 |=> o_col_valid == $past(i_frm_valid))
    else $error("color pulse mistimed");

endmodule

// ---- bench/fcpo_frame_src.sv ----
module fcpo_frame_src
  import fcpo_pkg::*;
(
  input  wire logic             i_clk,        // Clock
  output logic                  o_frm_valid,  // Frame strobe
  output logic [LEN_W-1:0]      o_frm_len,    // Frame length
  output logic                  o_frm_prof,   // Profiled flag
  input  wire logic             i_col_valid,  // Color pulse
  input  wire logic [1:0]       i_col         // Color seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines at time zero
  initial begin
    o_frm_valid = 1'b0;
    o_frm_len   = 16'h0000;
    o_frm_prof  = 1'b0;
  end

  // One frame, then stale lines inverted; color taken one cycle later
  task automatic send(input logic [LEN_W-1:0] len, input logic prof,
                      output logic vld, output logic [1:0] col);
    @(posedge i_clk);
    o_frm_valid <= 1'b1;
    o_frm_len   <= len;
    o_frm_prof  <= prof;
    @(posedge i_clk);
    o_frm_valid <= 1'b0;
    o_frm_len   <= ~len;
    o_frm_prof  <= ~prof;
    #1;
    vld = i_col_valid;
    col = i_col;
  endtask
endmodule

// ---- bench/fcpo_policer_tb.sv ----
module fcpo_policer_tb
  import fcpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_clk, i_arst_n, fv, fp, cv, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [LEN_W-1:0] fl;
  logic [1:0]       col, bresp, rresp;
  logic [7:0]       awa, ara;
  logic [31:0]      wd, rd;
  logic [3:0]       ws;
  int               mismatches, cmp_count;

  fcpo_frame_src u_src (.i_clk(i_clk), .o_frm_valid(fv), .o_frm_len(fl), .o_frm_prof(fp),
    .i_col_valid(cv), .i_col(col));
  fcpo_policer u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_frm_valid(fv), .i_frm_len(fl),
    .i_frm_prof(fp), .o_col_valid(cv), .o_col(col), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rd), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr));

  // Clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bus write; ready judged just before the edge it is sampled on
  task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb, b;
    logic [1:0] rsp;
    b = 1'b0;
    @(posedge i_clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    for (int k = 0; k < 50 && !b; k++) begin
      @(negedge i_clk);
      ta  = awv && awr;
      tw  = wv && wr;
      tb  = bv;
      rsp = bresp;
      @(posedge i_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) begin
        br <= 1'b0;
        b = 1'b1;
      end
    end
    chk("bvalid seen", 32'(b), 32'h0000_0001);
    chk("bresp", 32'(rsp), 32'(er));
  endtask

  // Bus read with response check
  task automatic rd32(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] rsp;
    tr = 1'b0;
    @(posedge i_clk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    for (int k = 0; k < 50 && !tr; k++) begin
      @(negedge i_clk);
      ta  = arv && arr;
      tr  = rv;
      rsp = rresp;
      d   = rd;
      @(posedge i_clk);
      if (ta) arv <= 1'b0;
      if (tr) rr <= 1'b0;
    end
    chk("rvalid seen", 32'(tr), 32'h0000_0001);
    chk("rresp", 32'(rsp), 32'(er));
  endtask

  task automatic tok_is(input logic [31:0] exp, input string nm);
    logic [31:0] d;
    rd32(ADDR_CTOK, RESP_OK, d);
    chk(nm, d, exp);
  endtask

  // Fill committed bucket to burst 100, refill then stopped
  task automatic fill(input logic [31:0] ctrl);
    wr32(ADDR_CBURST, 32'h0000_0064, RESP_OK);
    wr32(ADDR_CRATE, 32'h0000_FFFF, RESP_OK);
    wr32(ADDR_CCAP, 32'h0000_FFFF, RESP_OK);
    wr32(ADDR_CTRL, 32'h0000_0002, RESP_OK);
    wr32(ADDR_CTRL, ctrl, RESP_OK);
    tok_is(32'h0000_0064, "burst cap");
  endtask

  task automatic frame(input logic [15:0] len, input logic prof, input fcpo_color_e ec);
    logic v;
    logic [1:0] c;
    u_src.send(len, prof, v, c);
    chk("col valid", 32'(v), 32'h0000_0001);
    chk("color", 32'(c), 32'(ec));
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd32(ADDR_CTRL, RESP_OK, d);
    chk("ctrl", d, CTRL_RST);
    rd32(ADDR_DIV, RESP_OK, d);
    chk("div", d, 32'(DIV_RST));
    // Low lane only: upper byte of the data must be ignored
    ws <= 4'h1;
    wr32(ADDR_DIV, 32'h0000_AB00, RESP_OK);
    ws <= 4'hF;
    rd32(ADDR_DIV, RESP_OK, d);
    chk("div strobe", d, 32'h0000_0000);
    rd32(8'h40, RESP_ERR, d);
    wr32(8'h40, 32'h0000_0001, RESP_ERR);
    wr32(ADDR_CTOK, 32'h0000_0005, RESP_OK);
    tok_is(32'h0000_0000, "ro token");
  endtask

  task automatic t_rate_cap();
    logic [31:0] d;
    wr32(ADDR_DIV, 32'h0000_0000, RESP_OK);
    wr32(ADDR_CBURST, 32'h0000_0064, RESP_OK);
    wr32(ADDR_CRATE, 32'h0000_000D, RESP_OK);
    wr32(ADDR_CTRL, 32'h0000_0002, RESP_OK);
    // Divider must reach its zero reload before tokens may flow
    repeat (25) @(posedge i_clk);
    wr32(ADDR_CCAP, 32'h0000_0007, RESP_OK);
    wr32(ADDR_CTRL, 32'h0000_0000, RESP_OK);
    rd32(ADDR_CTOK, RESP_OK, d);
    chk("capped step", d % 7, 32'h0000_0000);
    chk("refilled", 32'(d == 0), 32'h0000_0000);
  endtask

  task automatic t_offsets();
    fill(32'h0000_0000);
    wr32(ADDR_OFS, 32'h0000_0004, RESP_OK);
    frame(16'h0068, 1'b1, FCPO_GREEN);
    tok_is(32'h0000_0000, "ofs 4 charge");
    frame(16'h0005, 1'b1, FCPO_RED);
    fill(32'h0000_0000);
    wr32(ADDR_OFS, 32'h0000_00EC, RESP_OK);
    frame(16'h0051, 1'b1, FCPO_RED);
    frame(16'h0050, 1'b1, FCPO_GREEN);
    tok_is(32'h0000_0000, "ofs -20 charge");
    wr32(ADDR_OFS, 32'h0000_0000, RESP_OK);
  endtask

  task automatic t_len_indep();
    fill(32'h0000_0001);
    frame(16'h012C, 1'b1, FCPO_GREEN);
    tok_is(32'hFFFF_FF38, "negative count");
    frame(16'h000A, 1'b1, FCPO_RED);
    frame(16'h05DC, 1'b0, FCPO_GREEN);
    tok_is(32'hFFFF_FF38, "unprofiled");
  endtask

  // Excess bucket gives Yellow; colour counters
  task automatic t_excess();
    logic [31:0] d;
    wr32(ADDR_EBURST, 32'h0000_0064, RESP_OK);
    wr32(ADDR_ERATE, 32'h0000_FFFF, RESP_OK);
    wr32(ADDR_ECAP, 32'h0000_FFFF, RESP_OK);
    fill(32'h0000_0000);
    frame(16'h0064, 1'b1, FCPO_GREEN);
    frame(16'h0032, 1'b1, FCPO_YELLOW);
    rd32(ADDR_ETOK, RESP_OK, d);
    chk("excess charge", d, 32'h0000_0032);
    rd32(ADDR_GCNT, RESP_OK, d);
    chk("green count", d, 32'h0000_0005);
    rd32(ADDR_RCNT, RESP_OK, d);
    chk("red count", d, 32'h0000_0003);
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    cmp_count  = 0;
    i_arst_n   = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd  = 32'h0000_0000;
    ws  = 4'hF;
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_rate_cap();
    t_offsets();
    t_len_indep();
    t_excess();
    wrap_up();
  end
endmodule
